// file: hdl/sld_pkg.sv
package sld_pkg;
  // Timing base
  localparam int CLK_HZ = 125_000_000;
  localparam int CYC_PER_MS = CLK_HZ / 1000;
  localparam int BLANK_MS = 100;
  localparam int ALLON_MS = 500;
  localparam int LABEL_MS = 600;
  localparam int ADDR_UNIT_MS = 100;
  localparam int WARN_CODE_MS = 2000;
  localparam int WARN_NORM_MS = 2000;
  localparam int ALARM_PHASE_MS = 1000;
  localparam int BLINK_HALF_MS = 250;
  localparam int LINK_INIT_MS = 100;

  // Register map, byte addresses
  localparam logic [3:0] OFS_DISP_CFG = 4'h0;
  localparam logic [3:0] OFS_CMD = 4'h4;
  localparam logic [3:0] OFS_STATUS = 4'h8;
  localparam int CFG_SEL_LSB = 0;
  localparam int CFG_POLE_LSB = 4;
  localparam int CFG_ADT_LSB = 8;
  localparam int CFG_REV_BIT = 16;
  localparam int CFG_ENH_LSB = 24;
  localparam int CMD_CLR_BIT = 0;
  localparam int ENH_SYNC_BIT = 4;
  localparam logic [31:0] CFG_MASK = 32'hFF01_FFFF;
  localparam logic [31:0] CFG_RST = 32'h0000_0F00;

  localparam logic [3:0] SEL_NORMAL = 4'h0;
  localparam logic [3:0] SEL_ADDR = 4'h4;
  localparam logic [3:0] SEL_SENSOR = 4'h9;
  localparam logic [3:0] POLE_CS = 4'h1;
  localparam logic signed [15:0] SPEED_FWD = 16'sh001E;
  localparam logic signed [15:0] SPEED_REV = 16'shFFE2;

  // Segment bit positions and glyphs
  localparam int SEG_A = 0;
  localparam int SEG_D = 3;
  localparam int SEG_E = 4;
  localparam int SEG_F = 5;
  localparam int SEG_G = 6;
  localparam int SEG_DP = 7;
  localparam logic [7:0] GLYPH_BLANK = 8'h00;
  localparam logic [7:0] GLYPH_ALL = 8'hFF;
  localparam logic [7:0] GLYPH_DASH = 8'h40;
  localparam logic [7:0] GLYPH_N = 8'h54;
  localparam logic [7:0] GLYPH_A = 8'h77;

  localparam logic [1:0] CST_INITIAL = 2'h0;
  localparam logic [1:0] CST_RING = 2'h1;
  localparam logic [1:0] CST_READY = 2'h2;
  localparam logic [1:0] CST_RUNNING = 2'h3;

  typedef enum logic [6:0] {
    ST_BLANK = 7'h01, ST_ALLON = 7'h02, ST_LABEL = 7'h04, ST_ADDR = 7'h08,
    ST_NORMAL = 7'h10, ST_WARN = 7'h20, ST_ALARM = 7'h40
  } sld_state_t;

  function automatic logic [7:0] hex_glyph(logic [3:0] v);
    logic [7:0] g;
    unique case (v)
      4'h0: g = 8'h3F;
      4'h1: g = 8'h06;
      4'h2: g = 8'h5B;
      4'h3: g = 8'h4F;
      4'h4: g = 8'h66;
      4'h5: g = 8'h6D;
      4'h6: g = 8'h7D;
      4'h7: g = 8'h07;
      4'h8: g = 8'h7F;
      4'h9: g = 8'h6F;
      4'hA: g = 8'h77;
      4'hB: g = 8'h7C;
      4'hC: g = 8'h39;
      4'hD: g = 8'h5E;
      4'hE: g = 8'h79;
      4'hF: g = 8'h71;
    endcase
    return g;
  endfunction : hex_glyph

  // Two decimal digits, tens in the upper byte
  function automatic logic [15:0] dec_pair(logic [7:0] v);
    logic [7:0] m;
    logic [7:0] t;
    logic [7:0] o;
    m = v % 8'h64;
    t = m / 8'h0A;
    o = m % 8'h0A;
    return {hex_glyph(t[3:0]), hex_glyph(o[3:0])};
  endfunction : dec_pair
endpackage : sld_pkg

// file: hdl/sld_tick_if.sv
`timescale 1ns/100ps
interface sld_tick_if;
  logic ms_tick;
  logic blink;
  modport src(output ms_tick, output blink);
  modport snk(input ms_tick, input blink);
endinterface : sld_tick_if

// file: hdl/sld_tick.sv
`timescale 1ns/100ps
module sld_tick #(
  parameter int CYC_PER_MS = sld_pkg::CYC_PER_MS
) (
  input wire logic core_clk,
  input wire logic rst,
  sld_tick_if.src tick
);
  import sld_pkg::*;

  logic [16:0] cyc_q, cyc_d;
  logic [15:0] ms_q, ms_d;
  logic tick_q, tick_d;
  logic blink_q, blink_d;

  always_comb begin
    cyc_d = cyc_q + 17'h00001;
    tick_d = 1'b0;
    ms_d = ms_q;
    blink_d = blink_q;
    if (cyc_q == 17'(CYC_PER_MS - 1)) begin
      cyc_d = '0;
      tick_d = 1'b1;
    end
    // Equal on and off phases for every blinking indicator
    if (tick_q) begin // [RL18]
      ms_d = ms_q + 16'h0001;
      if (ms_q == 16'(BLINK_HALF_MS - 1)) begin
        ms_d = '0;
        blink_d = ~blink_q;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cyc_q <= '0;
      ms_q <= '0;
      tick_q <= 1'b0;
      blink_q <= 1'b0;
    end else begin
      cyc_q <= cyc_d;
      ms_q <= ms_d;
      tick_q <= tick_d;
      blink_q <= blink_d;
    end
  end

  assign tick.ms_tick = tick_q;
  assign tick.blink = blink_q;
endmodule : sld_tick

// file: hdl/sld_netled.sv
`timescale 1ns/100ps
module sld_netled (
  input wire logic core_clk,
  input wire logic rst,
  sld_tick_if.snk tick,
  input wire logic enhance_sync,
  input wire logic [1:0] ctrl_state,
  input wire logic comm_sync,
  input wire logic net_alarm_clearable,
  input wire logic net_alarm_unclearable,
  input wire logic link_connected,
  input wire logic reset_cmd,
  output logic net_led_green,
  output logic net_led_red,
  output logic link_led_green
);
  import sld_pkg::*;

  logic green_q, green_d;
  logic red_q, red_d;
  logic link_q, link_d;
  logic [15:0] init_q, init_d;
  logic sync_ok;

  always_comb begin
    sync_ok = enhance_sync ? comm_sync : 1'b1; // [RL13]
    green_d = 1'b0;
    red_d = 1'b0;
    if (net_alarm_unclearable) begin // [RL14]
      red_d = 1'b1;
    end else if (net_alarm_clearable) begin
      red_d = tick.blink;
    end else begin
      unique case (ctrl_state) // [RL12]
        CST_INITIAL: green_d = 1'b0;
        CST_RING, CST_READY: green_d = tick.blink;
        CST_RUNNING: green_d = sync_ok ? 1'b1 : tick.blink;
      endcase
    end
    init_d = init_q;
    if (reset_cmd) begin
      init_d = 16'(LINK_INIT_MS);
    end else if (tick.ms_tick && init_q != '0) begin
      init_d = init_q - 16'h0001;
    end
    // Short lamp test at start-up or reset command
    link_d = link_connected || (init_q != '0); // [RL15] [RL17]
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      green_q <= 1'b0;
      red_q <= 1'b0;
      link_q <= 1'b0;
      init_q <= 16'(LINK_INIT_MS);
    end else begin
      green_q <= green_d;
      red_q <= red_d;
      link_q <= link_d;
      init_q <= init_d;
    end
  end

  assign net_led_green = green_q;
  assign net_led_red = red_q;
  assign link_led_green = link_q;

  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  chk_red_solid_lit: assert property ( // [RL14]
    net_alarm_unclearable |=> net_led_red && !net_led_green)
    else $error("Unclearable network alarm not shown solid red");
  chk_initial_dark: assert property ( // [RL12]
    ctrl_state == CST_INITIAL && !net_alarm_clearable
    && !net_alarm_unclearable |=> !net_led_green && !net_led_red)
    else $error("Network LED lit in initial state");
  chk_unsync_blink: assert property ( // [RL13]
    enhance_sync && ctrl_state == CST_RUNNING && !comm_sync
    && !net_alarm_clearable && !net_alarm_unclearable
    |=> net_led_green == $past(tick.blink))
    else $error("Running without sync must blink green");
  chk_link_lit: assert property ( // [RL15]
    link_connected |=> link_led_green)
    else $error("Link LED dark while connected");
endmodule : sld_netled

// file: hdl/sld_display.sv
// Notes on behaviour
// (RL1) Sensor selection with pole method 1: sensors right, direction left.
// (RL2) Sensors 1,2,3 light top, middle, bottom bars of right digit.
// (RL3) Sensor levels shown raw, before the reversal setting inverts them.
// (RL4) Upper-left at speed >= 30, lower-left at <= -30, else centre.
// (RL5) Sensor selection with other pole method shows the n-A glyph.
// (RL6) Undefined selector values are reserved; no user display offered.
// (RL7) Power-up: blank, all on, n-A label 0.6 s, address, normal.
// (RL8) Normal display shows servo on/off, marked by power and sync.
// (RL9) Alarm alternates decimal main code with left dot and sub code.
// (RL10) Warning code in hex 2 s alternates with normal; right dot blinks.
// (RL11) Latched alarm needs cause gone plus clear; unlatched only cause gone.
// (RL12) Enhance bit 4 clear: dark initial, blink config/ready, solid running.
// (RL13) Enhance bit 4 set: solid green only when running and synchronised.
// (RL14) Clearable network alarm blinks red, unclearable solid red; red wins.
// (RL15) Link LED green while upstream transmitter is connected.
// (RL16) Network alarm during other alarm leaves the earlier code displayed.
// (RL17) Link LED may flash briefly at power-up or reset command.
// (RL18) Network LED blink period fixed, from the clock, equal phases.
//
// Design decisions made here: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/100ps
module sld_display #(
  parameter int CYC_PER_MS = sld_pkg::CYC_PER_MS
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic servo_on,
  input wire logic main_power_on,
  input wire logic comm_sync,
  input wire logic signed [15:0] speed_mm_s,
  input wire logic commutation_sensor_1,
  input wire logic commutation_sensor_2,
  input wire logic commutation_sensor_3,
  input wire logic pole_estimate_done,
  input wire logic [7:0] rotary_address_switch,
  input wire logic alarm_cause,
  input wire logic alarm_latched,
  input wire logic [7:0] alarm_main_code,
  input wire logic [7:0] alarm_sub_code,
  input wire logic warning_active,
  input wire logic [7:0] warning_code,
  input wire logic [1:0] ctrl_state,
  input wire logic net_alarm_clearable,
  input wire logic net_alarm_unclearable,
  input wire logic link_connected,
  input wire logic reset_cmd,
  output logic [7:0] seg_left,
  output logic [7:0] seg_right,
  output logic [2:0] sensor_to_ctrl,
  output logic net_led_green,
  output logic net_led_red,
  output logic link_led_green
);
  import sld_pkg::*;

  sld_tick_if tick_if ();

  sld_tick #(.CYC_PER_MS(CYC_PER_MS)) u_tick (
    .core_clk(core_clk),
    .rst(rst),
    .tick(tick_if.src)
  );

  logic [31:0] cfg_q, cfg_d;
  logic [3:0] sel;
  logic [3:0] pole;
  logic [7:0] adt;
  logic rev;

  assign sel = cfg_q[CFG_SEL_LSB +: 4];
  assign pole = cfg_q[CFG_POLE_LSB +: 4];
  assign adt = cfg_q[CFG_ADT_LSB +: 8];
  assign rev = cfg_q[CFG_REV_BIT];

  sld_netled u_netled (
    .core_clk(core_clk),
    .rst(rst),
    .tick(tick_if.snk),
    .enhance_sync(cfg_q[CFG_ENH_LSB + ENH_SYNC_BIT]),
    .ctrl_state(ctrl_state),
    .comm_sync(comm_sync),
    .net_alarm_clearable(net_alarm_clearable),
    .net_alarm_unclearable(net_alarm_unclearable),
    .link_connected(link_connected),
    .reset_cmd(reset_cmd),
    .net_led_green(net_led_green),
    .net_led_red(net_led_red),
    .link_led_green(link_led_green)
  );

  // Bus slave state
  logic wait_q, wait_d;
  logic [31:0] rdata_q, rdata_d;
  logic clr_q, clr_d;
  logic wr_en;

  // Display state
  sld_state_t st_q, st_d;
  logic [15:0] tmr_q, tmr_d;
  logic alt_q, alt_d;
  logic [7:0] addr_q, addr_d;
  logic [7:0] main_q, main_d;
  logic [7:0] sub_q, sub_d;
  logic latch_q, latch_d;
  logic [7:0] segl_q, segl_d;
  logic [7:0] segr_q, segr_d;
  logic [2:0] sens_q, sens_d;
  logic release_ok;
  logic [7:0] norm_l;
  logic [7:0] norm_r;

  // One wait state per access, then a single-cycle answer
  always_comb begin
    wr_en = avs_write && !wait_q;
    wait_d = !((avs_read || avs_write) && wait_q);
    rdata_d = rdata_q;
    if (avs_read && wait_q) begin
      unique case (avs_address)
        OFS_DISP_CFG: rdata_d = cfg_q;
        OFS_CMD: rdata_d = {31'h0000_0000, clr_q};
        OFS_STATUS: rdata_d = {6'h00, net_led_red, net_led_green,
                               segr_q, segl_q, latch_q, st_q};
        default: rdata_d = '0;
      endcase
    end
    cfg_d = cfg_q;
    if (wr_en && avs_address == OFS_DISP_CFG) begin
      for (int i = 0; i < 4; i++) begin
        if (avs_byteenable[i]) begin
          cfg_d[8*i +: 8] = avs_writedata[8*i +: 8] & CFG_MASK[8*i +: 8];
        end
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wait_q <= 1'b1;
      rdata_q <= '0;
      cfg_q <= CFG_RST;
    end else begin
      wait_q <= wait_d;
      rdata_q <= rdata_d;
      cfg_q <= cfg_d;
    end
  end

  // Normal view, chosen by the display selector
  always_comb begin
    norm_l = GLYPH_BLANK;
    norm_r = GLYPH_BLANK;
    if (sel == SEL_SENSOR) begin
      if (pole == POLE_CS) begin // [RL1]
        norm_r[SEG_A] = commutation_sensor_1; // [RL2] [RL3]
        norm_r[SEG_G] = commutation_sensor_2;
        norm_r[SEG_D] = commutation_sensor_3;
        if (speed_mm_s >= SPEED_FWD) begin // [RL4]
          norm_l[SEG_F] = 1'b1;
        end else if (speed_mm_s <= SPEED_REV) begin
          norm_l[SEG_E] = 1'b1;
        end else begin
          norm_l[SEG_G] = 1'b1;
        end
      end else begin
        norm_l = GLYPH_N; // [RL5]
        norm_r = GLYPH_A;
      end
    end else if (sel == SEL_ADDR) begin
      {norm_l, norm_r} = dec_pair(addr_q);
    end else begin
      // Reserved selector codes fall back to the servo view
      norm_l = servo_on ? hex_glyph(4'h0) : GLYPH_DASH; // [RL6] [RL8]
      norm_r = servo_on ? hex_glyph(4'h0) : GLYPH_DASH;
      norm_l[SEG_DP] = pole_estimate_done;
      norm_r[SEG_DP] = !(main_power_on && comm_sync); // [RL8]
    end
  end

  // Sequencer
  always_comb begin
    st_d = st_q;
    tmr_d = (tick_if.ms_tick && tmr_q != '1) ? tmr_q + 16'h0001 : tmr_q;
    alt_d = alt_q;
    addr_d = addr_q;
    main_d = main_q;
    sub_d = sub_q;
    latch_d = latch_q;
    release_ok = !alarm_cause && (!latch_q || clr_q); // [RL11]
    unique case (st_q) // [RL7]
      ST_BLANK: begin
        addr_d = rotary_address_switch;
        if (tmr_q >= 16'(BLANK_MS)) st_d = ST_ALLON;
      end
      ST_ALLON: begin
        if (tmr_q >= 16'(ALLON_MS)) st_d = ST_LABEL;
      end
      ST_LABEL: begin
        if (tmr_q >= 16'(LABEL_MS)) st_d = ST_ADDR;
      end
      ST_ADDR: begin
        if (tmr_q >= 16'(adt) * 16'(ADDR_UNIT_MS)) st_d = ST_NORMAL;
      end
      ST_NORMAL, ST_WARN: begin
        if (alarm_cause) begin // [RL9] [RL16]
          st_d = ST_ALARM;
          main_d = alarm_main_code;
          sub_d = alarm_sub_code;
          latch_d = alarm_latched;
          alt_d = 1'b0;
        end else if (st_q == ST_NORMAL) begin
          if (warning_active && tmr_q >= 16'(WARN_NORM_MS)) begin // [RL10]
            st_d = ST_WARN;
          end
        end else if (!warning_active || tmr_q >= 16'(WARN_CODE_MS)) begin
          st_d = ST_NORMAL;
        end
      end
      ST_ALARM: begin
        if (release_ok) begin // [RL11]
          st_d = ST_NORMAL;
        end else if (tmr_q >= 16'(ALARM_PHASE_MS)) begin
          alt_d = ~alt_q;
          tmr_d = '0;
        end
      end
    endcase
    if (st_d != st_q) tmr_d = '0;
    // Clear request: a write that lands with the consume still wins
    clr_d = clr_q;
    if (st_q != ST_ALARM || release_ok) clr_d = 1'b0;
    if (wr_en && avs_address == OFS_CMD && avs_byteenable[0]
        && avs_writedata[CMD_CLR_BIT]) begin
      clr_d = 1'b1;
    end
  end

  // Segment drive
  always_comb begin
    segl_d = GLYPH_BLANK;
    segr_d = GLYPH_BLANK;
    sens_d = {commutation_sensor_3, commutation_sensor_2,
              commutation_sensor_1} ^ {3{rev}}; // [RL3]
    unique case (st_q)
      ST_BLANK: begin
        segl_d = GLYPH_BLANK;
        segr_d = GLYPH_BLANK;
      end
      ST_ALLON: begin
        segl_d = GLYPH_ALL;
        segr_d = GLYPH_ALL;
      end
      ST_LABEL: begin
        segl_d = GLYPH_N;
        segr_d = GLYPH_A;
      end
      ST_ADDR: {segl_d, segr_d} = dec_pair(addr_q);
      ST_NORMAL: begin
        segl_d = norm_l;
        segr_d = norm_r;
      end
      ST_WARN: begin // [RL10]
        segl_d = hex_glyph(warning_code[7:4]);
        segr_d = hex_glyph(warning_code[3:0]);
        segr_d[SEG_DP] = tick_if.blink;
      end
      ST_ALARM: begin // [RL9]
        {segl_d, segr_d} = alt_q ? dec_pair(sub_q) : dec_pair(main_q);
        segl_d[SEG_DP] = !alt_q;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_q <= ST_BLANK;
      tmr_q <= '0;
      alt_q <= 1'b0;
      addr_q <= '0;
      main_q <= '0;
      sub_q <= '0;
      latch_q <= 1'b0;
      clr_q <= 1'b0;
      segl_q <= GLYPH_BLANK;
      segr_q <= GLYPH_BLANK;
      sens_q <= '0;
    end else begin
      st_q <= st_d;
      tmr_q <= tmr_d;
      alt_q <= alt_d;
      addr_q <= addr_d;
      main_q <= main_d;
      sub_q <= sub_d;
      latch_q <= latch_d;
      clr_q <= clr_d;
      segl_q <= segl_d;
      segr_q <= segr_d;
      sens_q <= sens_d;
    end
  end

  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
  assign seg_left = segl_q;
  assign seg_right = segr_q;
  assign sensor_to_ctrl = sens_q;

  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  chk_sensor_bars: assert property ( // [RL2]
    st_q == ST_NORMAL && sel == SEL_SENSOR && pole == POLE_CS
    |=> seg_right[SEG_A] == $past(commutation_sensor_1)
    && seg_right[SEG_G] == $past(commutation_sensor_2)
    && seg_right[SEG_D] == $past(commutation_sensor_3))
    else $error("Sensor bars do not follow sensor inputs");
  chk_raw_vs_ctrl: assert property ( // [RL3]
    st_q == ST_NORMAL && sel == SEL_SENSOR && pole == POLE_CS && rev
    |=> seg_right[SEG_A] == !sensor_to_ctrl[0])
    else $error("Displayed sensor not the raw level");
  chk_dir_forward: assert property ( // [RL4]
    st_q == ST_NORMAL && sel == SEL_SENSOR && pole == POLE_CS
    && speed_mm_s >= SPEED_FWD |=> seg_left[SEG_F] && !seg_left[SEG_G])
    else $error("Forward direction segment wrong");
  chk_na_glyph: assert property ( // [RL5]
    st_q == ST_NORMAL && sel == SEL_SENSOR && pole != POLE_CS
    |=> seg_left == GLYPH_N && seg_right == GLYPH_A)
    else $error("Not-applicable glyph missing");
  chk_boot_order: assert property ( // [RL7]
    st_q == ST_LABEL |=> st_q == ST_LABEL || st_q == ST_ADDR)
    else $error("Label step left to a wrong state");
  chk_alarm_entry: assert property ( // [RL9]
    st_q == ST_NORMAL && alarm_cause |=> st_q == ST_ALARM ##1
    seg_left[SEG_DP] == !alt_q)
    else $error("Alarm not entered with main-code dot");
  chk_latched_hold: assert property ( // [RL11]
    st_q == ST_ALARM && latch_q && !clr_q |=> st_q == ST_ALARM)
    else $error("Latched alarm left without clear");
  chk_alarm_keep: assert property ( // [RL16]
    st_q == ST_ALARM && $past(st_q) == ST_ALARM
    |-> $stable(main_q) && $stable(sub_q))
    else $error("Shown alarm code replaced");
  chk_warn_dot: assert property ( // [RL10]
    st_q == ST_WARN |=> seg_right[SEG_DP] == $past(tick_if.blink))
    else $error("Warning right dot not blinking");
endmodule : sld_display

// file: dv/sld_panel.sv
`timescale 1ns/100ps
module sld_panel (
  input wire logic core_clk,
  input wire logic clr,
  input wire logic net_led_green,
  input wire logic net_led_red,
  input wire logic right_dot,
  output logic [15:0] green_flips,
  output logic [15:0] red_flips,
  output logic [15:0] dot_flips
);
  logic [2:0] last_q;
  // Operator eye: counts lamp changes seen since the last clear
  always_ff @(posedge core_clk) begin
    last_q <= {right_dot, net_led_red, net_led_green};
    if (clr) begin
      green_flips <= 16'h0000;
      red_flips <= 16'h0000;
      dot_flips <= 16'h0000;
    end else begin
      green_flips <= green_flips + 16'(net_led_green != last_q[0]);
      red_flips <= red_flips + 16'(net_led_red != last_q[1]);
      dot_flips <= dot_flips + 16'(right_dot != last_q[2]);
    end
  end
endmodule : sld_panel

// file: dv/tb_sld_display.sv
`timescale 1ns/100ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin errors++; \
  $display("wrong value at %0t: got %h exp %h", $time, a, e); end end
module tb_sld_display;
  import sld_pkg::*;
  logic core_clk, rst, avs_read, avs_write, avs_waitrequest, clr;
  logic [3:0] avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic servo_on, main_power_on, comm_sync, pole_estimate_done;
  logic signed [15:0] speed_mm_s;
  logic commutation_sensor_1, commutation_sensor_2, commutation_sensor_3;
  logic [7:0] rotary_address_switch, alarm_main_code, alarm_sub_code;
  logic alarm_cause, alarm_latched, warning_active, link_connected;
  logic [7:0] warning_code, seg_left, seg_right;
  logic [1:0] ctrl_state;
  logic net_alarm_clearable, net_alarm_unclearable, reset_cmd;
  logic [2:0] sensor_to_ctrl;
  logic net_led_green, net_led_red, link_led_green;
  logic [15:0] green_flips, red_flips, dot_flips;
  int errors, checks;
  int sp [4] = '{30, -30, 29, -29};

  sld_display #(.CYC_PER_MS(10)) i_sld_display (.*);
  sld_panel i_sld_panel (.core_clk(core_clk), .clr(clr),
    .net_led_green(net_led_green), .net_led_red(net_led_red),
    .right_dot(seg_right[7]), .green_flips(green_flips),
    .red_flips(red_flips), .dot_flips(dot_flips));

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task wt(input int n);
    repeat (n) @(posedge core_clk);
  endtask : wt

  task bus(input logic w, input logic [3:0] a, input logic [31:0] d,
           output logic [31:0] q);
    int n;
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    if (n >= 100) errors++;
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task wait_l(input logic [7:0] l, input int lim);
    int n;
    n = 0;
    while (seg_left !== l && n < lim) begin
      @(posedge core_clk);
      n++;
    end
    `CHK(seg_left, l)
  endtask : wait_l

  task flips_clr;
    clr <= 1'b1;
    @(posedge core_clk);
    clr <= 1'b0;
  endtask : flips_clr

  // 2 means the lamp changed during the window
  function automatic logic [1:0] mode(logic [15:0] f, logic lvl);
    return f != 16'h0000 ? 2'h2 : {1'b0, lvl};
  endfunction : mode

  task net_case(input logic [7:0] enh, input logic [1:0] st,
                input logic sy, ca, ua, input logic [1:0] gm, rm);
    bus(1'b1, OFS_DISP_CFG, {enh, 24'h00_0100}, rd);
    ctrl_state <= st;
    comm_sync <= sy;
    net_alarm_clearable <= ca;
    net_alarm_unclearable <= ua;
    wt(10);
    flips_clr;
    wt(3000);
    `CHK(mode(green_flips, net_led_green), gm)
    `CHK(mode(red_flips, net_led_red), rm)
  endtask : net_case

  task summarize;
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : summarize

  initial begin
    wt(95000);
    errors++;
    summarize;
  end

  initial begin
    rst = 1'b1;
    clr = 1'b1;
    {avs_address, avs_read, avs_write, avs_writedata} = '0;
    avs_byteenable = 4'hF;
    {servo_on, main_power_on, comm_sync, pole_estimate_done} = 4'h0;
    speed_mm_s = 16'sh0000;
    {commutation_sensor_3, commutation_sensor_2, commutation_sensor_1} = 3'h0;
    rotary_address_switch = 8'h03;
    {alarm_cause, alarm_latched, warning_active} = 3'h0;
    alarm_main_code = 8'h15;
    alarm_sub_code = 8'h05;
    warning_code = 8'h5A;
    ctrl_state = CST_INITIAL;
    {net_alarm_clearable, net_alarm_unclearable} = 2'h0;
    {link_connected, reset_cmd} = 2'h0;
    errors = 0;
    checks = 0;
    wt(4);
    rst <= 1'b0;
    bus(1'b0, OFS_DISP_CFG, 32'h0, rd);
    `CHK(rd, CFG_RST)
    bus(1'b1, OFS_DISP_CFG, 32'h0002_0100, rd);
    bus(1'b0, OFS_DISP_CFG, 32'h0, rd);
    `CHK(rd, 32'h0000_0100)
    bus(1'b0, 4'hC, 32'h0, rd);
    `CHK(rd, 32'h0000_0000)
    wt(400);
    `CHK({seg_left, seg_right}, {GLYPH_BLANK, GLYPH_BLANK})
    `CHK(link_led_green, 1'b1)
    wt(3000);
    `CHK({seg_left, seg_right}, {GLYPH_ALL, GLYPH_ALL})
    wt(5500);
    `CHK({seg_left, seg_right}, {GLYPH_N, GLYPH_A})
    wt(3500);
    `CHK({seg_left, seg_right}, 16'h3F4F)
    wt(1500);
    `CHK({seg_left, seg_right}, 16'h40C0)
    {servo_on, main_power_on, comm_sync, pole_estimate_done} <= 4'hF;
    wt(3);
    `CHK({seg_left, seg_right}, 16'hBF3F)
    bus(1'b1, OFS_DISP_CFG, 32'h0001_0119, rd);
    for (int i = 0; i < 8; i++) begin
      {commutation_sensor_3, commutation_sensor_2,
       commutation_sensor_1} <= i[2:0];
      speed_mm_s <= 16'(sp[i % 4]);
      wt(3);
      `CHK(seg_right, {1'b0, i[1], 2'b00, i[2], 2'b00, i[0]})
      `CHK(seg_left, sp[i % 4] >= SPEED_FWD ? 8'h20 :
           sp[i % 4] <= SPEED_REV ? 8'h10 : 8'h40)
      `CHK(sensor_to_ctrl, ~i[2:0])
    end
    bus(1'b1, OFS_DISP_CFG, 32'h0000_0129, rd);
    wt(3);
    `CHK({seg_left, seg_right}, {GLYPH_N, GLYPH_A})
    bus(1'b1, OFS_DISP_CFG, 32'h0000_0104, rd);
    wt(3);
    `CHK({seg_left, seg_right}, 16'h3F4F)
    bus(1'b1, OFS_DISP_CFG, 32'h0000_010F, rd);
    wt(3);
    `CHK({seg_left, seg_right}, 16'hBF3F)
    link_connected <= 1'b1;
    wt(3);
    `CHK(link_led_green, 1'b1)
    link_connected <= 1'b0;
    wt(3);
    `CHK(link_led_green, 1'b0)
    reset_cmd <= 1'b1;
    wt(1);
    reset_cmd <= 1'b0;
    wt(3);
    `CHK(link_led_green, 1'b1)
    wt(1100);
    `CHK(link_led_green, 1'b0)
    net_case(8'h00, CST_INITIAL, 1'b0, 1'b0, 1'b0, 2'h0, 2'h0);
    net_case(8'h00, CST_RING, 1'b0, 1'b0, 1'b0, 2'h2, 2'h0);
    net_case(8'h00, CST_READY, 1'b0, 1'b0, 1'b0, 2'h2, 2'h0);
    net_case(8'h00, CST_RUNNING, 1'b0, 1'b0, 1'b0, 2'h1, 2'h0);
    net_case(8'h10, CST_RUNNING, 1'b0, 1'b0, 1'b0, 2'h2, 2'h0);
    net_case(8'h10, CST_READY, 1'b1, 1'b0, 1'b0, 2'h2, 2'h0);
    net_case(8'h10, CST_INITIAL, 1'b1, 1'b0, 1'b0, 2'h0, 2'h0);
    net_case(8'h10, CST_RUNNING, 1'b1, 1'b0, 1'b0, 2'h1, 2'h0);
    net_case(8'h10, CST_RUNNING, 1'b1, 1'b1, 1'b0, 2'h0, 2'h2);
    net_case(8'h10, CST_RUNNING, 1'b1, 1'b0, 1'b1, 2'h0, 2'h1);
    net_alarm_unclearable <= 1'b0;
    warning_active <= 1'b1;
    wait_l(8'h6D, 45000);
    `CHK(seg_right[6:0], 7'h77)
    flips_clr;
    wt(6000);
    `CHK(dot_flips != 16'h0000, 1'b1)
    wait_l(8'hBF, 25000);
    warning_active <= 1'b0;
    wt(10);
    {alarm_cause, alarm_latched} <= 2'h3;
    wait_l(8'hDB, 200);
    `CHK(seg_right, 8'h06)
    wait_l(8'h3F, 12000);
    `CHK(seg_right, 8'h6D)
    net_alarm_clearable <= 1'b1;
    wait_l(8'hDB, 12000);
    `CHK(seg_right, 8'h06)
    `CHK(net_led_green, 1'b0)
    alarm_cause <= 1'b0;
    wt(3000);
    `CHK(seg_left === 8'hBF, 1'b0)
    bus(1'b1, OFS_CMD, 32'h0000_0001, rd);
    wait_l(8'hBF, 50);
    {alarm_cause, alarm_latched} <= 2'h2;
    wait_l(8'hDB, 200);
    alarm_cause <= 1'b0;
    wait_l(8'hBF, 50);
    summarize;
  end
endmodule : tb_sld_display
